//--- logic/sfd_pkg.sv
// Package of constants for the frame start timestamp strobe block
package sfd_pkg;
  // ==========================================
  // Bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int IDX_W = 10;
  localparam int IDX_LSB = 2;
  // ==========================================
  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_PHY_CONTROL_MAIN = 10'h001F;
  localparam logic [IDX_W-1:0] IDX_LANE_SKEW_STATUS = 10'h0055;
  localparam logic [IDX_W-1:0] IDX_ALIGN_FIFO_CONTROL = 10'h00E9;
  localparam logic [IDX_W-1:0] IDX_PIN_ROUTE_CTRL_A = 10'h0171;
  localparam logic [IDX_W-1:0] IDX_PIN_ROUTE_CTRL_B = 10'h0172;
  localparam logic [IDX_W-1:0] IDX_STROBE_PHASE_CTRL = 10'h0180;
  // ==========================================
  // Fields and values
  localparam int SOFT_RESTART_BIT = 14;
  localparam logic [REG_W-1:0] FIFO_INIT_VAL = 16'hDF22;
  localparam logic [REG_W-1:0] REG_RESET_VAL = 16'h0000;
  localparam int SKEW_W = 4;
  localparam int MASTER_SKEW_LSB = 4;
  localparam int SLAVE_SKEW_LSB = 0;
  localparam int TX_PHASE_LSB = 0;
  localparam int RX_PHASE_LSB = 4;
  localparam int ROUTE_SEL_W = 4;
  localparam int PINS_PER_REG = 4;
  localparam logic [ROUTE_SEL_W-1:0] ROUTE_NONE = 4'h0;
  localparam logic [ROUTE_SEL_W-1:0] ROUTE_TX = 4'h1;
  localparam logic [ROUTE_SEL_W-1:0] ROUTE_RX = 4'h2;
  localparam logic [ROUTE_SEL_W-1:0] ROUTE_EITHER = 4'h3;
  // ==========================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PHASE_STEP_NS = 8;
  localparam int STEP_CYC_RAW = (PHASE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_STEP_CYC = (STEP_CYC_RAW < 1) ? 1 : STEP_CYC_RAW;
  localparam int DELAY_W = 8;
  localparam logic [SKEW_W-1:0] SKEW_LIMIT_DEF = 4'h7;
endpackage

//--- logic/sfd_delay_line.sv
// Delays one strobe by a number of phase steps and emits a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module sfd_delay_line
  import sfd_pkg::*;
#(
  parameter int STEP_CYC = PHASE_STEP_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic eventIn,
  input wire logic [DELAY_W-1:0] delaySteps,
  output logic strobeOut
);
  // ==========================================
  // Countdown
  logic busy_q;
  logic [DELAY_W+3:0] count_q;
  logic strobe_q;
  wire logic [DELAY_W+3:0] delayCyc = (DELAY_W+4)'(delaySteps * STEP_CYC);
  wire logic startNow = eventIn && !busy_q;
  wire logic fireNow = startNow ? (delayCyc == '0) : (busy_q && count_q == (DELAY_W+4)'(1));
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      count_q <= '0;
      strobe_q <= 1'b0;
    end
    else
    begin
      strobe_q <= fireNow;
      if (startNow && delayCyc != '0)
      begin
        busy_q <= 1'b1;
        count_q <= delayCyc;
      end
      else if (busy_q)
      begin
        count_q <= count_q - (DELAY_W+4)'(1);
        busy_q <= (count_q != (DELAY_W+4)'(1));
      end
    end
  end
  assign strobeOut = strobe_q;
endmodule
`default_nettype wire

//--- logic/sfd_strobe_top.sv
// Frame start timestamp strobes with phase shift, pin routing and skew report
// Contract
// - Emit a strobe at the delimiter, separately for transmit and receive.
// - Transmit strobe marks delimiter driven; receive strobe marks first symbol.
// - A phase field delays each strobe in steps of 8 ns; here a step is rounded up to one 10 ns clock cycle.
// - Two routing registers steer strobes to pins; small variant has only second.
// - Extra receive latency is added only when pair alignment is needed.
// - Added latency is latched at link-up and fixed for the link.
// - At 1000 Mb the alignment latency is bounded and reported.
// - Soft restart bit written makes the device restart the link.
// - Master at 1000 Mb reports latency in status bits 7 to 4.
// - Slave at 1000 Mb reports latency in status bits 3 to 0.
// - At 100 Mb no latency is added nor reported.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module sfd_strobe_top
  import sfd_pkg::*;
#(
  parameter bit ROUTE_A_PRESENT = 1'b1,
  parameter logic [SKEW_W-1:0] SKEW_LIMIT = SKEW_LIMIT_DEF
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [sfd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [sfd_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sfd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [sfd_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txDelimiterDriven,
  input wire logic rxFirstSymbol,
  input wire logic linkUp,
  input wire logic speed1000,
  input wire logic speed100,
  input wire logic isMaster,
  input wire logic [sfd_pkg::SKEW_W-1:0] laneSkewMeasured,
  output logic txFrameStartStrobe,
  output logic rxFrameStartStrobe,
  output logic [2*sfd_pkg::PINS_PER_REG-1:0] strobePins,
  output logic linkRestart
);
  import sfd_pkg::*;

  // ==========================================
  // Register state
  logic [REG_W-1:0] phyControl_q;
  logic [REG_W-1:0] alignFifo_q;
  logic [REG_W-1:0] routeA_q;
  logic [REG_W-1:0] routeB_q;
  logic [REG_W-1:0] phase_q;
  logic restart_q;

  // ==========================================
  // Write channel
  logic awReady_q;
  logic wReady_q;
  logic awHeld_q;
  logic wHeld_q;
  logic [IDX_W-1:0] wIdx_q;
  logic [REG_W-1:0] wData_q;
  logic [1:0] wStrb_q;
  logic bValid_q;
  logic [1:0] bResp_q;

  function automatic logic known(input logic [IDX_W-1:0] idx);
    known = (idx == IDX_PHY_CONTROL_MAIN) || (idx == IDX_LANE_SKEW_STATUS) ||
            (idx == IDX_ALIGN_FIFO_CONTROL) || (idx == IDX_PIN_ROUTE_CTRL_B) ||
            (idx == IDX_STROBE_PHASE_CTRL) || (ROUTE_A_PRESENT && idx == IDX_PIN_ROUTE_CTRL_A);
  endfunction

  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old, input logic [REG_W-1:0] nw,
                                             input logic [1:0] strb);
    merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction

  wire logic awTake = s_axi_awvalid && awReady_q;
  wire logic wTake = s_axi_wvalid && wReady_q;
  wire logic doWrite = awHeld_q && wHeld_q && !bValid_q;
  wire logic bDone = bValid_q && s_axi_bready;
  wire logic wKnown = known(wIdx_q);
  wire logic wrCtrl = doWrite && wIdx_q == IDX_PHY_CONTROL_MAIN;
  wire logic wrFifo = doWrite && wIdx_q == IDX_ALIGN_FIFO_CONTROL;
  wire logic wrRouteA = doWrite && ROUTE_A_PRESENT && wIdx_q == IDX_PIN_ROUTE_CTRL_A;
  wire logic wrRouteB = doWrite && wIdx_q == IDX_PIN_ROUTE_CTRL_B;
  wire logic wrPhase = doWrite && wIdx_q == IDX_STROBE_PHASE_CTRL;
  wire logic [REG_W-1:0] ctrlMerged = merge(phyControl_q, wData_q, wStrb_q);
  wire logic restartReq = wrCtrl && ctrlMerged[SOFT_RESTART_BIT];

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      awReady_q <= 1'b0;
      wReady_q <= 1'b0;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      wIdx_q <= '0;
      wData_q <= REG_RESET_VAL;
      wStrb_q <= 2'h0;
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
    end
    else
    begin
      if (awTake)
      begin
        awReady_q <= 1'b0;
        awHeld_q <= 1'b1;
        wIdx_q <= s_axi_awaddr[IDX_LSB +: IDX_W];
      end
      else if (!awHeld_q)
        awReady_q <= 1'b1;
      if (wTake)
      begin
        wReady_q <= 1'b0;
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata[REG_W-1:0];
        wStrb_q <= s_axi_wstrb[1:0];
      end
      else if (!wHeld_q)
        wReady_q <= 1'b1;
      if (doWrite)
      begin
        bValid_q <= 1'b1;
        bResp_q <= wKnown ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bDone)
      begin
        bValid_q <= 1'b0;
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // Registers written by software
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      phyControl_q <= REG_RESET_VAL;
      alignFifo_q <= REG_RESET_VAL;
      routeA_q <= REG_RESET_VAL;
      routeB_q <= REG_RESET_VAL;
      phase_q <= REG_RESET_VAL;
      restart_q <= 1'b0;
    end
    else
    begin
      restart_q <= restartReq;
      if (wrCtrl)
      begin
        phyControl_q <= ctrlMerged;
        phyControl_q[SOFT_RESTART_BIT] <= 1'b0;
      end
      if (wrFifo)
        alignFifo_q <= merge(alignFifo_q, wData_q, wStrb_q);
      if (wrRouteA)
        routeA_q <= merge(routeA_q, wData_q, wStrb_q);
      if (wrRouteB)
        routeB_q <= merge(routeB_q, wData_q, wStrb_q);
      if (wrPhase)
        phase_q <= merge(phase_q, wData_q, wStrb_q);
    end
  end

  // ==========================================
  // Alignment latency latched per link
  logic linkUpPrev_q;
  logic armed_q;
  logic [SKEW_W-1:0] skew_q;
  wire logic linkRise = linkUp && !linkUpPrev_q;
  wire logic fifoReady = (alignFifo_q == FIFO_INIT_VAL);
  wire logic [SKEW_W-1:0] skewBounded = (laneSkewMeasured > SKEW_LIMIT) ? SKEW_LIMIT : laneSkewMeasured;
  wire logic applySkew = armed_q && speed1000 && !speed100;
  wire logic [SKEW_W-1:0] skewApplied = applySkew ? skew_q : '0;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      linkUpPrev_q <= 1'b0;
      armed_q <= 1'b0;
      skew_q <= '0;
    end
    else
    begin
      linkUpPrev_q <= linkUp && !restartReq;
      if (!linkUp || restartReq)
      begin
        armed_q <= 1'b0;
        skew_q <= '0;
      end
      else if (linkRise)
      begin
        armed_q <= fifoReady && speed1000;
        skew_q <= fifoReady ? skewBounded : laneSkewMeasured;
      end
    end
  end

  wire logic [REG_W-1:0] skewStatus = !applySkew ? REG_RESET_VAL :
    isMaster ? REG_W'({skewApplied, {MASTER_SKEW_LSB{1'b0}}}) :
    REG_W'(skewApplied) << SLAVE_SKEW_LSB;

  // ==========================================
  // Read channel
  logic arReady_q;
  logic rValid_q;
  logic [DATA_W-1:0] rData_q;
  logic [1:0] rResp_q;
  wire logic [IDX_W-1:0] rIdx = s_axi_araddr[IDX_LSB +: IDX_W];
  wire logic arTake = s_axi_arvalid && arReady_q;
  wire logic [REG_W-1:0] rMux =
    (rIdx == IDX_PHY_CONTROL_MAIN) ? phyControl_q :
    (rIdx == IDX_LANE_SKEW_STATUS) ? skewStatus :
    (rIdx == IDX_ALIGN_FIFO_CONTROL) ? alignFifo_q :
    (rIdx == IDX_PIN_ROUTE_CTRL_A && ROUTE_A_PRESENT) ? routeA_q :
    (rIdx == IDX_PIN_ROUTE_CTRL_B) ? routeB_q :
    (rIdx == IDX_STROBE_PHASE_CTRL) ? phase_q : REG_RESET_VAL;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b0;
      rData_q <= '0;
      rResp_q <= RESP_OKAY;
    end
    else if (arTake)
    begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b1;
      rData_q <= DATA_W'(rMux);
      rResp_q <= known(rIdx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rValid_q && s_axi_rready)
      rValid_q <= 1'b0;
    else if (!rValid_q)
      arReady_q <= 1'b1;
  end

  // ==========================================
  // Strobe generation
  wire logic [DELAY_W-1:0] txSteps = DELAY_W'(phase_q[TX_PHASE_LSB +: SKEW_W]);
  wire logic [DELAY_W-1:0] rxSteps = DELAY_W'(phase_q[RX_PHASE_LSB +: SKEW_W]) + DELAY_W'(skewApplied);

  sfd_delay_line #(.STEP_CYC(PHASE_STEP_CYC)) txDelay (
    .sys_clk(sys_clk),
    .rst(rst),
    .eventIn(txDelimiterDriven),
    .delaySteps(txSteps),
    .strobeOut(txFrameStartStrobe)
  );

  sfd_delay_line #(.STEP_CYC(PHASE_STEP_CYC)) rxDelay (
    .sys_clk(sys_clk),
    .rst(rst),
    .eventIn(rxFirstSymbol),
    .delaySteps(rxSteps),
    .strobeOut(rxFrameStartStrobe)
  );

  // ==========================================
  // Pin routing
  function automatic logic pick(input logic [ROUTE_SEL_W-1:0] sel, input logic tx, input logic rx);
    pick = (sel == ROUTE_TX) ? tx : (sel == ROUTE_RX) ? rx : (sel == ROUTE_EITHER) ? (tx || rx) : 1'b0;
  endfunction

  logic [2*PINS_PER_REG-1:0] pins_q;
  logic [2*PINS_PER_REG-1:0] pins_d;
  always_comb
  begin
    pins_d = '0;
    for (int i = 0; i < PINS_PER_REG; i++)
    begin
      pins_d[i] = ROUTE_A_PRESENT && pick(routeA_q[i*ROUTE_SEL_W +: ROUTE_SEL_W],
                                          txFrameStartStrobe, rxFrameStartStrobe);
      pins_d[PINS_PER_REG+i] = pick(routeB_q[i*ROUTE_SEL_W +: ROUTE_SEL_W],
                                    txFrameStartStrobe, rxFrameStartStrobe);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pins_q <= '0;
    else
      pins_q <= pins_d;
  end

  assign strobePins = pins_q;
  assign linkRestart = restart_q;
  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
endmodule
`default_nettype wire

//--- sim/sfd_strobe_properties.sv
// Assertions on bus handshakes and strobe pulses of the strobe block
`timescale 1ns/1ps
`default_nettype none
module sfd_strobe_props
  import sfd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [sfd_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic txFrameStartStrobe,
  input wire logic rxFrameStartStrobe,
  input wire logic linkRestart
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ==========================================
  // Pulses
  tx_pulse_a: assert property (txFrameStartStrobe |=> !txFrameStartStrobe) else $error("tx strobe long");
  rx_pulse_a: assert property (rxFrameStartStrobe |=> !rxFrameStartStrobe) else $error("rx strobe long");
  restart_pulse_a: assert property (linkRestart |=> !linkRestart) else $error("restart long");
  // ==========================================
  // Bus
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write answer");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready early");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read answer");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper bits set");
endmodule
bind sfd_strobe_top sfd_strobe_props i_props (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .txFrameStartStrobe, .rxFrameStartStrobe, .linkRestart);
`default_nettype wire

//--- sim/sfd_far_model.sv
// Frame event source and strobe timer on the MAC side
`timescale 1ns/1ps
`default_nettype none
module sfd_far_model
(
  input wire logic sys_clk,
  input wire logic txStrobe,
  input wire logic rxStrobe,
  input wire logic pinTx,
  input wire logic pinRx,
  output logic txEvent,
  output logic rxEvent,
  output int txLat,
  output int rxLat,
  output int pinTxLat,
  output int pinRxLat,
  output int txCnt,
  output int rxCnt
);
  int tc = 0;
  int rc = 0;
  initial
  begin
    txEvent = 1'b0;
    rxEvent = 1'b0;
    {txLat, rxLat, pinTxLat, pinRxLat, txCnt, rxCnt} = '0;
  end
  // ==========================================
  // One-cycle frame event
  task automatic send(input bit rx);
    @(posedge sys_clk);
    if (rx) rxEvent <= 1'b1;
    else txEvent <= 1'b1;
    @(posedge sys_clk);
    rxEvent <= 1'b0;
    txEvent <= 1'b0;
  endtask
  // ==========================================
  // Timers from event to strobe
  always @(posedge sys_clk)
  begin
    tc <= txEvent ? 0 : tc + 1;
    rc <= rxEvent ? 0 : rc + 1;
    if (txStrobe === 1'b1) txLat <= tc + 1;
    if (txStrobe === 1'b1) txCnt <= txCnt + 1;
    if (rxStrobe === 1'b1) rxLat <= rc + 1;
    if (rxStrobe === 1'b1) rxCnt <= rxCnt + 1;
    if (pinTx === 1'b1) pinTxLat <= tc + 1;
    if (pinRx === 1'b1) pinRxLat <= rc + 1;
  end
endmodule
`default_nettype wire

//--- sim/tb_frame_start_timestamp_pulse.sv
// Self-checking bench for the frame start strobe block
`timescale 1ns/1ps
`default_nettype none
module tb_frame_start_timestamp_pulse;
  import sfd_pkg::*;
  logic sys_clk, rst, awV, awR, wV, wR, bV, bR, arV, arR, rV, rR, txEv, rxEv, lRst, txS, rxS;
  logic linkUp, sp1k, sp100, master;
  logic [11:0] awA, arA;
  logic [31:0] wD, rD;
  logic [3:0] wS, skewIn;
  logic [1:0] bResp, rResp;
  logic [7:0] pins;
  logic [15:0] lf = 16'd33925;
  logic [15:0] ph;
  logic [15:0] mdl [logic [9:0]];
  logic [9:0] idxs [6] = '{IDX_PHY_CONTROL_MAIN, IDX_LANE_SKEW_STATUS, IDX_ALIGN_FIFO_CONTROL,
    IDX_PIN_ROUTE_CTRL_A, IDX_PIN_ROUTE_CTRL_B, IDX_STROBE_PHASE_CTRL};
  int num_errors = 0;
  int checks_done = 0;
  int restarts = 0;
  int eitherCnt = 0;
  int n, c, e, addSk, txL, rxL, ptL, prL, txC, rxC;
  sfd_strobe_top i_dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
    .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_wvalid(wV), .s_axi_wready(wR),
    .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV),
    .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rR),
    .txDelimiterDriven(txEv), .rxFirstSymbol(rxEv), .linkUp(linkUp), .speed1000(sp1k), .speed100(sp100),
    .isMaster(master), .laneSkewMeasured(skewIn), .txFrameStartStrobe(txS), .rxFrameStartStrobe(rxS),
    .strobePins(pins), .linkRestart(lRst));
  sfd_far_model i_far (.sys_clk(sys_clk), .txStrobe(txS), .rxStrobe(rxS), .pinTx(pins[0]), .pinRx(pins[4]),
    .txEvent(txEv), .rxEvent(rxEv), .txLat(txL), .rxLat(rxL), .pinTxLat(ptL), .pinRxLat(prL), .txCnt(txC),
    .rxCnt(rxC));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (lRst === 1'b1) restarts++;
  always @(posedge sys_clk) if (pins[1] === 1'b1) eitherCnt++;
  // ==========================================
  // Helpers
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] okay(input logic [9:0] ix);
    return (ix inside {idxs}) ? RESP_OKAY : RESP_SLVERR;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic step();
    @(posedge sys_clk);
    n++;
    if (n > 200)
    begin
      num_errors++;
      close_out();
    end
  endtask
  // ==========================================
  // Bus cycles
  task automatic wr(input logic [9:0] ix, input logic [15:0] d);
    @(posedge sys_clk);
    awA <= {ix, 2'b00};
    wD <= {16'h0000, d};
    awV <= 1'b1;
    wV <= 1'b1;
    n = 0;
    while (!(bV === 1'b1 && bR === 1'b1))
    begin
      step();
      if (awR === 1'b1) awV <= 1'b0;
      if (wR === 1'b1) wV <= 1'b0;
      if (bV === 1'b1 && bR !== 1'b1) bR <= 1'b1;
    end
    bR <= 1'b0;
    chk("bresp", okay(ix), bResp);
    if (ix inside {idxs} && ix != IDX_LANE_SKEW_STATUS) mdl[ix] = d & ((ix == IDX_PHY_CONTROL_MAIN) ? 16'hbfff : 16'hffff);
  endtask
  task automatic rd(input logic [9:0] ix);
    @(posedge sys_clk);
    arA <= {ix, 2'b00};
    arV <= 1'b1;
    n = 0;
    while (!(rV === 1'b1 && rR === 1'b1))
    begin
      step();
      if (arR === 1'b1) arV <= 1'b0;
      if (rV === 1'b1 && rR !== 1'b1) rR <= 1'b1;
    end
    rR <= 1'b0;
    chk("rdata", (ix inside {idxs}) ? mdl[ix] : 32'h0, rD);
    chk("rresp", okay(ix), rResp);
  endtask
  // ==========================================
  // Frames and links
  task automatic frame(input bit rx, input int lat);
    c = rx ? rxC : txC;
    e = eitherCnt;
    i_far.send(rx);
    n = 0;
    while ((rx ? rxC : txC) == c) step();
    repeat (2) @(posedge sys_clk);
    chk("latency", lat, rx ? rxL : txL);
    chk("pin latency", lat + 1, rx ? prL : ptL);
    chk("either pin", e + 1, eitherCnt);
  endtask
  task automatic relink(input bit fast, input bit ms, input logic [3:0] sk);
    @(posedge sys_clk);
    linkUp <= 1'b0;
    sp1k <= fast;
    sp100 <= !fast;
    master <= ms;
    skewIn <= sk;
    repeat (2) @(posedge sys_clk);
    linkUp <= 1'b1;
    addSk = (mdl[IDX_ALIGN_FIFO_CONTROL] == FIFO_INIT_VAL && fast) ? ((sk > SKEW_LIMIT_DEF) ? SKEW_LIMIT_DEF : sk) : 0;
    mdl[IDX_LANE_SKEW_STATUS] = ms ? 16'(addSk << 4) : 16'(addSk);
    repeat (3) @(posedge sys_clk);
    skewIn <= ~sk;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    {rst, awV, wV, bR, arV, rR, linkUp, sp1k, sp100, master} = 10'h200;
    {awA, arA, wD, skewIn} = '0;
    wS = 4'hf;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    foreach (idxs[i]) mdl[idxs[i]] = REG_RESET_VAL;
    foreach (idxs[i]) rd(idxs[i]);
    rd(10'h100);
    wr(10'h100, 16'hffff);
    foreach (idxs[i])
    begin
      lf = nxt(lf);
      wr(idxs[i], lf);
      rd(idxs[i]);
    end
    c = restarts;
    wr(IDX_PHY_CONTROL_MAIN, 16'h4001);
    rd(IDX_PHY_CONTROL_MAIN);
    chk("restarts", c + 1, restarts);
    wr(IDX_PIN_ROUTE_CTRL_A, 16'h0031);
    wr(IDX_PIN_ROUTE_CTRL_B, 16'h0002);
    for (int k = 0; k < 3; k++)
    begin
      lf = nxt(lf);
      ph = (k == 0) ? 16'h0000 : {8'h00, lf[7:0]};
      wr(IDX_STROBE_PHASE_CTRL, ph);
      frame(1'b0, ph[3:0] + 1);
      frame(1'b1, ph[7:4] + 1);
    end
    ph = 16'h000f;
    wr(IDX_STROBE_PHASE_CTRL, ph);
    c = txC;
    i_far.send(1'b0);
    i_far.send(1'b0);
    repeat (25) @(posedge sys_clk);
    chk("strobe count", c + 1, txC);
    wr(IDX_ALIGN_FIFO_CONTROL, FIFO_INIT_VAL);
    for (int m = 0; m < 4; m++)
    begin
      lf = nxt(lf);
      if (m == 3) wr(IDX_ALIGN_FIFO_CONTROL, 16'h0000);
      relink(m != 2, m == 0, lf[3:0]);
      rd(IDX_LANE_SKEW_STATUS);
      frame(1'b1, addSk + 1);
      if (m == 1)
      begin
        c = restarts;
        wr(IDX_PHY_CONTROL_MAIN, 16'h4000);
        chk("restarts", c + 1, restarts);
        addSk = (skewIn > SKEW_LIMIT_DEF) ? SKEW_LIMIT_DEF : skewIn;
        mdl[IDX_LANE_SKEW_STATUS] = 16'(addSk);
        rd(IDX_LANE_SKEW_STATUS);
        frame(1'b1, addSk + 1);
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
